// [hw/isoav_pkg.sv]
// constants for the isochronous a/v transmit and receive control registers
// assumes a 9-bit register address and 32-bit register data
package isoav_pkg;
	// register port shape
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	// register offsets
	localparam logic [8:0] OFS_TX_PEND = 9'h02C;
	localparam logic [8:0] OFS_TX_EN   = 9'h030;
	localparam logic [8:0] OFS_TX_CTL  = 9'h034;
	localparam logic [8:0] OFS_TX_LVL  = 9'h038;
	localparam logic [8:0] OFS_RX_CTL  = 9'h040;
	// reset values
	localparam logic [31:0] RST_TX_PEND = 32'h00000000;
	localparam logic [31:0] RST_TX_EN   = 32'h00000000;
	localparam logic [31:0] RST_TX_CTL  = 32'h00000000;
	localparam logic [31:0] RST_TX_LVL  = 32'h00000003;
	localparam logic [31:0] RST_RX_CTL  = 32'h00000041;
	// transmitter event bits, pending and enable alike
	localparam int IRQ_N      = 7;
	localparam int IRQ_STAMP  = 6;
	localparam int IRQ_DONE   = 5;
	localparam int IRQ_DBC    = 4;
	localparam int IRQ_INERR  = 3;
	localparam int IRQ_CYCLE  = 2;
	localparam int IRQ_FULL   = 1;
	localparam int IRQ_EMPTY  = 0;
	// header control fields
	localparam int TAG_LSB  = 14;
	localparam int CH_LSB   = 8;
	localparam int SPD_LSB  = 4;
	localparam int SYNC_LSB = 0;
	// speed codes
	localparam logic [1:0] SPD_S100 = 2'h0;
	localparam logic [1:0] SPD_S200 = 2'h1;
	localparam logic [1:0] SPD_S400 = 2'h2;
	localparam logic [1:0] SPD_RSVD = 2'h3;
	// buffer level bits and thresholds
	localparam int LVL_NO_SPACE  = 3;
	localparam int LVL_ONE_LEFT  = 2;
	localparam int LVL_FIVE_FREE = 1;
	localparam int LVL_VACANT    = 0;
	localparam int FREE_ONE      = 1;
	localparam int FREE_FIVE     = 5;
	// receiver control bits
	localparam int RX_DROP  = 6;
	localparam int RX_READY = 5;
	localparam int RX_EN    = 4;
	localparam int RX_PAD   = 2;
	localparam int RX_STAMP = 1;
	localparam int RX_RST   = 0;
endpackage : isoav_pkg

// [hw/isoav_rx_if.sv]
// carrier between the register bank and the receiver control helper
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface isoav_rx_if;
	logic rx_enable_bit;   // enable bit as written
	logic rx_soft_reset;   // receiver reset bit as written
	logic rx_enable_active; // enable taken at packet boundary
	logic rx_packet_ready; // synchronised packet-ready level
	modport bank (output rx_enable_bit, output rx_soft_reset,
		input rx_enable_active, input rx_packet_ready);
	modport ctl (input rx_enable_bit, input rx_soft_reset,
		output rx_enable_active, output rx_packet_ready);
endinterface : isoav_rx_if
`default_nettype wire

// [hw/isoav_rx_ctl.sv]
// receiver enable sampling and crossing of receiver status
// assumes arrival toggle and ready level come from the application clock domain
`timescale 1ns/1ps
`default_nettype none
module isoav_rx_ctl (
	input  wire logic  sys_clk,
	input  wire logic  resetn,
	input  wire logic  rx_arrival_toggle,
	input  wire logic  rx_ready_async,
	isoav_rx_if.ctl    rx
);
	logic [2:0] tog_sync_reg;  // toggle synchroniser plus edge stage
	logic [2:0] tog_sync_next;
	logic [1:0] rdy_sync_reg;  // ready level synchroniser
	logic [1:0] rdy_sync_next;
	logic       active_reg;    // enable as last sampled
	logic       active_next;
	logic       arrival;       // one pulse per new bus packet

	// next values for crossing and enable sampling
	always_comb begin
		tog_sync_next = {tog_sync_reg[1:0], rx_arrival_toggle};
		rdy_sync_next = {rdy_sync_reg[0], rx_ready_async};
		// only second and third stages are compared
		arrival       = tog_sync_reg[2] ^ tog_sync_reg[1];
		active_next   = active_reg;
		if (rx.rx_soft_reset) begin
			active_next = 1'b0;
		end else if (arrival) begin
			active_next = rx.rx_enable_bit;
		end
	end

	// registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tog_sync_reg <= 3'h0;
			rdy_sync_reg <= 2'h0;
			active_reg   <= 1'b0;
		end else begin
			tog_sync_reg <= tog_sync_next;
			rdy_sync_reg <= rdy_sync_next;
			active_reg   <= active_next;
		end
	end

	assign rx.rx_enable_active = active_reg;
	assign rx.rx_packet_ready  = rdy_sync_reg[1];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_en_hold_gap: assert property (
		!arrival && !rx.rx_soft_reset |=> $stable(active_reg))
		else $error("receiver enable changed between packets");
	a_en_at_arrival: assert property (
		arrival && !rx.rx_soft_reset |=> active_reg == $past(rx.rx_enable_bit))
		else $error("receiver enable not taken at arrival");
	a_rst_clears_en: assert property (
		rx.rx_soft_reset |=> !active_reg)
		else $error("receiver enable survived reset bit");
endmodule : isoav_rx_ctl
`default_nettype wire

// [hw/isoav_regs.sv]
// register bank for the isochronous a/v transmit and receive control
// assumes a single-cycle register port on sys_clk and same-clock tx events
`timescale 1ns/1ps
`default_nettype none
module isoav_regs #(
	parameter int LVL_W = 8 // width of buffer fill counts
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic [8:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [31:0]       reg_wdata,
	output logic      [31:0]       reg_rdata,
	input  wire logic [6:0]        tx_events,
	input  wire logic [LVL_W-1:0]  tx_free_q,
	input  wire logic [LVL_W-1:0]  tx_stored_q,
	input  wire logic              rx_arrival_toggle,
	input  wire logic              rx_ready_async,
	output logic                   tx_irq,
	output logic                   tx_discard_input,
	output logic                   tx_discard_payload,
	output logic      [1:0]        tx_tag,
	output logic      [5:0]        tx_channel,
	output logic      [1:0]        tx_speed,
	output logic                   tx_speed_ok,
	output logic      [3:0]        tx_sync,
	output logic                   drop_unreliable_packets,
	output logic      [1:0]        rx_byte_pad_count,
	output logic                   stamp_processing_enable,
	output logic                   rx_soft_reset,
	output logic                   rx_enable
);
	isoav_rx_if rx_bus (); // link to receiver helper

	// register state
	logic [6:0]  pend_reg;  // pending event bits
	logic [6:0]  pend_next;
	logic [6:0]  en_reg;    // enable bits
	logic [6:0]  en_next;
	logic [15:0] ctl_reg;   // header control word
	logic [15:0] ctl_next;
	logic [3:0]  lvl_reg;   // buffer level flags
	logic [3:0]  lvl_next;
	logic [6:0]  rxc_reg;   // receiver control, bit 5 unused here
	logic [6:0]  rxc_next;
	logic [31:0] rdata_reg; // read data
	logic [31:0] rdata_next;
	logic [1:0]  dis_reg;   // discard strobes
	logic [1:0]  dis_next;
	// decoded write strobes
	logic        wr_pend;
	logic        wr_en;
	logic        wr_ctl;
	logic        wr_rxc;
	logic [6:0]  clr_mask;  // write-one-to-clear mask

	// address decode for writes
	always_comb begin
		wr_pend  = reg_wr && (reg_addr == isoav_pkg::OFS_TX_PEND);
		wr_en    = reg_wr && (reg_addr == isoav_pkg::OFS_TX_EN);
		wr_ctl   = reg_wr && (reg_addr == isoav_pkg::OFS_TX_CTL);
		wr_rxc   = reg_wr && (reg_addr == isoav_pkg::OFS_RX_CTL);
		clr_mask = wr_pend ? reg_wdata[6:0] : 7'h00;
	end

	// per-bit pending update
	generate
		for (genvar i = 0; i < isoav_pkg::IRQ_N; i++) begin : g_pend
			always_comb begin
				// set wins over a same-cycle clear
				pend_next[i] = tx_events[i] | (pend_reg[i] & ~clr_mask[i]);
			end
		end
	endgenerate

	// configuration writes and level flags
	always_comb begin
		en_next = wr_en ? reg_wdata[6:0] : en_reg;
		// speed code stored
		// bits 7:6 carry no field and stay zero
		ctl_next = wr_ctl ? (reg_wdata[15:0] & 16'hFF3F) : ctl_reg;
		rxc_next = rxc_reg;
		if (wr_rxc) begin
			// bit 5 is read-only status, not stored
			rxc_next = reg_wdata[6:0] & 7'h5F;
		end
		lvl_next[isoav_pkg::LVL_NO_SPACE] = (tx_free_q == '0);
		lvl_next[isoav_pkg::LVL_ONE_LEFT] =
			(tx_free_q == LVL_W'(isoav_pkg::FREE_ONE));
		lvl_next[isoav_pkg::LVL_FIVE_FREE] =
			(tx_free_q >= LVL_W'(isoav_pkg::FREE_FIVE));
		lvl_next[isoav_pkg::LVL_VACANT] = (tx_stored_q == '0);
		dis_next[0] = tx_events[isoav_pkg::IRQ_INERR];
		dis_next[1] = tx_events[isoav_pkg::IRQ_CYCLE];
	end

	// read mux, unmapped reads give zero
	always_comb begin
		rdata_next = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				isoav_pkg::OFS_TX_PEND: rdata_next = {25'h0000000, pend_reg};
				isoav_pkg::OFS_TX_EN:   rdata_next = {25'h0000000, en_reg};
				isoav_pkg::OFS_TX_CTL:  rdata_next = {16'h0000, ctl_reg};
				isoav_pkg::OFS_TX_LVL:  rdata_next = {28'h0000000, lvl_reg};
				isoav_pkg::OFS_RX_CTL: begin
					rdata_next = {25'h0000000, rxc_reg};
					rdata_next[isoav_pkg::RX_READY] = rx_bus.rx_packet_ready;
				end
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	// all bank registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pend_reg  <= isoav_pkg::RST_TX_PEND[6:0];
			en_reg    <= isoav_pkg::RST_TX_EN[6:0];
			ctl_reg   <= isoav_pkg::RST_TX_CTL[15:0];
			lvl_reg   <= isoav_pkg::RST_TX_LVL[3:0];
			rxc_reg   <= isoav_pkg::RST_RX_CTL[6:0];
			rdata_reg <= 32'h00000000;
			dis_reg   <= 2'h0;
		end else begin
			pend_reg  <= pend_next;
			en_reg    <= en_next;
			ctl_reg   <= ctl_next;
			lvl_reg   <= lvl_next;
			rxc_reg   <= rxc_next;
			rdata_reg <= rdata_next;
			dis_reg   <= dis_next;
		end
	end

	// receiver helper
	isoav_rx_ctl u_rx_ctl (
		.sys_clk           (sys_clk),
		.resetn            (resetn),
		.rx_arrival_toggle (rx_arrival_toggle),
		.rx_ready_async    (rx_ready_async),
		.rx                (rx_bus.ctl)
	);

	// control bits toward receiver helper
	assign rx_bus.rx_enable_bit = rxc_reg[isoav_pkg::RX_EN];
	assign rx_bus.rx_soft_reset = rxc_reg[isoav_pkg::RX_RST];

	// outputs
	assign reg_rdata = rdata_reg;
	assign tx_irq             = |(pend_reg & en_reg);
	assign tx_discard_input   = dis_reg[0];
	assign tx_discard_payload = dis_reg[1];
	assign tx_tag     = ctl_reg[isoav_pkg::TAG_LSB +: 2];
	assign tx_channel = ctl_reg[isoav_pkg::CH_LSB +: 6];
	assign tx_speed    = ctl_reg[isoav_pkg::SPD_LSB +: 2];
	assign tx_speed_ok = (tx_speed != isoav_pkg::SPD_RSVD);
	assign tx_sync     = ctl_reg[isoav_pkg::SYNC_LSB +: 4];
	assign drop_unreliable_packets = rxc_reg[isoav_pkg::RX_DROP];
	assign rx_byte_pad_count = rxc_reg[isoav_pkg::RX_PAD +: 2];
	assign stamp_processing_enable = rxc_reg[isoav_pkg::RX_STAMP];
	assign rx_soft_reset = rxc_reg[isoav_pkg::RX_RST];
	assign rx_enable     = rx_bus.rx_enable_active;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// write of a header word
	sequence s_ctl_write;
		reg_wr && reg_addr == isoav_pkg::OFS_TX_CTL;
	endsequence
	// ready input steady long enough to cross
	sequence s_ready_stable;
		rx_ready_async [*3];
	endsequence
	// read of receiver control
	sequence s_rxc_read;
		reg_rd && reg_addr == isoav_pkg::OFS_RX_CTL;
	endsequence
	// clear and event meet on one bit
	sequence s_clear_meets_event;
		wr_pend && (reg_wdata[6:0] & tx_events) != 7'h00;
	endsequence

	a_stamp_sets: assert property (
		tx_events[6] |=> pend_reg[6])
		else $error("stamp event lost");
	a_done_sets: assert property (
		tx_events[5] |=> pend_reg[5])
		else $error("payload done event lost");
	a_dbc_sets: assert property (
		tx_events[4] |=> pend_reg[4])
		else $error("block count event lost");
	a_inerr_drop: assert property (
		tx_events[3] |=> pend_reg[3] && tx_discard_input)
		else $error("input error not flagged");
	a_cycle_drop: assert property (
		tx_events[2] |=> pend_reg[2] && tx_discard_payload)
		else $error("lost cycle not flagged");
	a_full_sets: assert property (
		tx_events[1] |=> pend_reg[1])
		else $error("bank full event lost");
	a_empty_sets: assert property (
		tx_events[0] |=> pend_reg[0])
		else $error("bank empty event lost");
	a_pend_clear: assert property (
		wr_pend && reg_wdata[4:2] == 3'h7 && tx_events[4:2] == 3'h0
		|=> pend_reg[4:2] == 3'h0)
		else $error("pending bits not cleared");
	a_pend_upper: assert property (
		reg_rd && reg_addr == isoav_pkg::OFS_TX_PEND
		|=> reg_rdata[31:7] == 25'h0000000)
		else $error("upper pending bits nonzero");
	a_en_readback: assert property (
		wr_en ##1 !wr_en ##1 reg_rd && reg_addr == isoav_pkg::OFS_TX_EN && !wr_en
		|=> reg_rdata[6:0] == $past(reg_wdata[6:0], 3))
		else $error("enable bits not held");
	a_tag_channel: assert property (
		s_ctl_write |=> tx_tag == $past(reg_wdata[15:14])
		&& tx_channel == $past(reg_wdata[13:8]))
		else $error("tag or channel not applied");
	a_sync_code: assert property (
		s_ctl_write |=> tx_sync == $past(reg_wdata[3:0]))
		else $error("sync code not applied");
	a_speed_code: assert property (
		s_ctl_write |=> tx_speed == $past(reg_wdata[5:4])
		&& tx_speed_ok == ($past(reg_wdata[5:4]) != 2'h3))
		else $error("speed code wrong");
	a_full_flag: assert property (
		tx_free_q == '0 |=> lvl_reg[3] && !lvl_reg[2] && !lvl_reg[1])
		else $error("full flag wrong");
	a_one_left: assert property (
		tx_free_q == LVL_W'(1) |=> lvl_reg[2] && !lvl_reg[3])
		else $error("one-left flag wrong");
	a_five_free: assert property (
		tx_free_q == LVL_W'(4) |=> !lvl_reg[1])
		else $error("five-free flag set with four");
	a_vacant: assert property (
		$changed(tx_stored_q) |=> lvl_reg[0] == ($past(tx_stored_q) == '0))
		else $error("vacant flag wrong");
	a_drop_ctl: assert property (
		wr_rxc |=> drop_unreliable_packets == $past(reg_wdata[6]))
		else $error("drop control not applied");
	a_ready_read: assert property (
		s_ready_stable ##0 s_rxc_read |=> reg_rdata[5])
		else $error("packet ready not visible");
	a_pad_count: assert property (
		wr_rxc |=> rx_byte_pad_count == $past(reg_wdata[3:2]))
		else $error("pad count not applied");
	a_stamp_en: assert property (
		wr_rxc |=> stamp_processing_enable == $past(reg_wdata[1]))
		else $error("stamp enable not applied");
	a_rx_reset: assert property (
		wr_rxc && reg_wdata[0] |=> rx_soft_reset ##1 !rx_enable)
		else $error("receiver reset not applied");
	a_irq_masked: assert property (
		tx_events[3] && en_reg[3] && !wr_en |=> tx_irq)
		else $error("enabled event gave no irq");
	a_pend_sticky: assert property (
		pend_reg[6] && !clr_mask[6] |=> pend_reg[6])
		else $error("pending bit dropped without clear");
	// pulse widths of the discard strobes
	a_inerr_pulse: assert property (
		!tx_events[3] |=> !tx_discard_input)
		else $error("input discard strobe too long");
	a_cycle_pulse: assert property (
		!tx_events[2] |=> !tx_discard_payload)
		else $error("payload discard strobe too long");
	// read-back and reserved bits
	a_en_upper: assert property (
		reg_rd && reg_addr == isoav_pkg::OFS_TX_EN
		|=> reg_rdata[31:7] == 25'h0000000)
		else $error("upper enable bits nonzero");
	a_ctl_gap_zero: assert property (
		s_ctl_write |=> ctl_reg[7:6] == 2'h0)
		else $error("unused header bits stored");
	a_one_left_off: assert property (
		tx_free_q == LVL_W'(2) |=> !lvl_reg[2])
		else $error("one-left flag set with two");
	a_five_at_five: assert property (
		tx_free_q == LVL_W'(5) |=> lvl_reg[1])
		else $error("five-free flag clear with five");
	a_ready_bit_ro: assert property (
		wr_rxc |=> !rxc_reg[5])
		else $error("ready bit stored by write");
	// interrupt line and pending clears
	a_irq_quiet: assert property (
		(pend_reg & en_reg) == 7'h00 |-> !tx_irq)
		else $error("irq without enabled pending bit");
	a_pend_cleared: assert property (
		!tx_events[6] && clr_mask[6] |=> !pend_reg[6])
		else $error("pending bit not cleared by one");
	a_set_wins: assert property (
		s_clear_meets_event |=> (pend_reg & $past(reg_wdata[6:0] & tx_events))
		== $past(reg_wdata[6:0] & tx_events))
		else $error("clear beat a same-cycle event");
endmodule : isoav_regs
`default_nettype wire

// [testbench/isoav_dp_model.sv]
// datapath-side model: tx event pulses, buffer counts, rx arrival and ready
// assumes sys_clk from the bench; drives 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module isoav_dp_model (
	input  wire logic       sys_clk,
	output logic      [6:0] tx_events,
	output logic      [7:0] tx_free_q,
	output logic      [7:0] tx_stored_q,
	output logic            rx_arrival_toggle,
	output logic            rx_ready_async
);
	// idle datapath: buffer empty, nothing received
	initial begin
		tx_events = 7'h00;
		tx_free_q = 8'h08;
		tx_stored_q = 8'h00;
		rx_arrival_toggle = 1'b0;
		rx_ready_async = 1'b0;
	end
	task automatic pulse(input logic [6:0] e);
		@(posedge sys_clk) #1 tx_events = e;
		@(posedge sys_clk) #1 tx_events = 7'h00;
	endtask : pulse
	// buffer fill counts, held as levels
	task automatic level(input logic [7:0] f, input logic [7:0] s);
		@(posedge sys_clk) #1 tx_free_q = f;
		tx_stored_q = s;
	endtask : level
	// new bus packet marks a boundary
	task automatic arrive();
		@(posedge sys_clk) #1 rx_arrival_toggle = ~rx_arrival_toggle;
	endtask : arrive
	task automatic ready(input logic v);
		@(posedge sys_clk) #1 rx_ready_async = v;
	endtask : ready
endmodule : isoav_dp_model
`default_nettype wire

// [testbench/iso_av_tx_rx_control_regs_tb_top.sv]
// self-checking bench for the isochronous a/v control register bank
// assumes single-cycle strobe register port, datapath driven by the model
`timescale 1ns/1ps
`default_nettype none
module iso_av_tx_rx_control_regs_tb_top;
	logic        sys_clk;   // 200 MHz
	logic        resetn;    // async, active low
	logic [8:0]  reg_addr;  // register offset
	logic        reg_wr;    // write strobe
	logic        reg_rd;    // read strobe
	logic [31:0] reg_wdata; // write data
	logic [31:0] reg_rdata; // read data
	logic [6:0]  tx_events;
	logic [7:0]  tx_free_q;
	logic [7:0]  tx_stored_q;
	logic        rx_arrival_toggle;
	logic        rx_ready_async;
	logic        tx_irq, tx_discard_input, tx_discard_payload, tx_speed_ok;
	logic [1:0]  tx_tag, tx_speed, rx_byte_pad_count;
	logic [5:0]  tx_channel;
	logic [3:0]  tx_sync;
	logic        drop_unreliable_packets, stamp_processing_enable, rx_soft_reset, rx_enable;
	int          err_count = 0; // mismatches
	int          tests_run = 0; // comparisons
	int          cyc = 0;       // timeout counter
	logic [31:0] seed = 32'hAAA4; // xorshift state
	logic [31:0] m_pend, m_en, m_ctl, m_rxc, v; // reference model
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	isoav_regs #(.LVL_W(8)) dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.tx_events(tx_events), .tx_free_q(tx_free_q), .tx_stored_q(tx_stored_q),
		.rx_arrival_toggle(rx_arrival_toggle), .rx_ready_async(rx_ready_async),
		.tx_irq(tx_irq), .tx_discard_input(tx_discard_input),
		.tx_discard_payload(tx_discard_payload), .tx_tag(tx_tag), .tx_channel(tx_channel),
		.tx_speed(tx_speed), .tx_speed_ok(tx_speed_ok), .tx_sync(tx_sync),
		.drop_unreliable_packets(drop_unreliable_packets), .rx_byte_pad_count(rx_byte_pad_count),
		.stamp_processing_enable(stamp_processing_enable), .rx_soft_reset(rx_soft_reset),
		.rx_enable(rx_enable));
	isoav_dp_model dp (.sys_clk(sys_clk), .tx_events(tx_events), .tx_free_q(tx_free_q),
		.tx_stored_q(tx_stored_q), .rx_arrival_toggle(rx_arrival_toggle),
		.rx_ready_async(rx_ready_async));
	// xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// verdict and end of run
	task automatic end_of_test();
		if (err_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// single comparison point
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// register write, one strobe cycle
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge sys_clk) #1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk) #1 reg_wr = 1'b0;
	endtask : wr
	// register read, data one cycle after the strobe
	task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
		@(posedge sys_clk) #1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge sys_clk) #1 reg_rd = 1'b0;
		chk(reg_rdata, exp);
	endtask : rchk
	// bounded wait for the sampled enable
	task automatic wait_en(input logic e);
		for (int n = 0; n < 10 && rx_enable !== e; n++) @(posedge sys_clk) #1;
	endtask : wait_en
	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_of_test();
		end
	end
	// main sequence
	initial begin
		resetn = 1'b0;
		reg_addr = 9'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h00000000;
		m_pend = 32'h0;
		m_rxc = isoav_pkg::RST_RX_CTL;
		repeat (2) @(posedge sys_clk);
		#1 resetn = 1'b1;
		// reset values of every register
		rchk(isoav_pkg::OFS_TX_PEND, isoav_pkg::RST_TX_PEND);
		rchk(isoav_pkg::OFS_TX_EN, isoav_pkg::RST_TX_EN);
		rchk(isoav_pkg::OFS_TX_CTL, isoav_pkg::RST_TX_CTL);
		rchk(isoav_pkg::OFS_TX_LVL, isoav_pkg::RST_TX_LVL);
		rchk(isoav_pkg::OFS_RX_CTL, isoav_pkg::RST_RX_CTL);
		chk(32'(drop_unreliable_packets), 32'h1);
		wr(isoav_pkg::OFS_TX_EN, 32'hFFFFFFFF);
		rchk(isoav_pkg::OFS_TX_EN, 32'h0000007F);
		// each event alone, random enables
		for (int i = 0; i < 7; i++) begin
			m_en = rnd() & 32'h7F;
			wr(isoav_pkg::OFS_TX_EN, m_en);
			dp.pulse(7'(1 << i));
			m_pend = m_pend | (32'h1 << i);
			chk(32'(tx_discard_input), 32'(i == 3));
			chk(32'(tx_discard_payload), 32'(i == 2));
			chk(32'(tx_irq), 32'((m_pend & m_en) != 0));
		end
		// upper bits neither stick nor clear
		wr(isoav_pkg::OFS_TX_PEND, 32'hFFFFFF80);
		rchk(isoav_pkg::OFS_TX_PEND, m_pend);
		// write-one clears one bit at a time
		for (int i = 0; i < 7; i++) begin
			wr(isoav_pkg::OFS_TX_PEND, 32'h1 << i);
			m_pend = m_pend & ~(32'h1 << i);
			rchk(isoav_pkg::OFS_TX_PEND, m_pend);
			chk(32'(tx_irq), 32'((m_pend & m_en) != 0));
		end
		// self-recovering conditions report again once cleared
		dp.pulse(7'h1C);
		rchk(isoav_pkg::OFS_TX_PEND, 32'h0000001C);
		wr(isoav_pkg::OFS_TX_PEND, 32'h0000001C);
		rchk(isoav_pkg::OFS_TX_PEND, 32'h0);
		// event and clear on one edge: the event wins
		fork
			dp.pulse(7'h01);
			wr(isoav_pkg::OFS_TX_PEND, 32'h00000001);
		join
		rchk(isoav_pkg::OFS_TX_PEND, 32'h00000001);
		// header fields, every speed code
		for (int s = 0; s < 4; s++) begin
			v = (rnd() & 32'hFFCF) | (s << 4);
			wr(isoav_pkg::OFS_TX_CTL, v | 32'hFFFF0000);
			rchk(isoav_pkg::OFS_TX_CTL, v & 32'hFF3F);
			chk(32'(tx_tag), 32'(v[15:14]));
			chk(32'(tx_channel), 32'(v[13:8]));
			chk(32'(tx_speed), 32'(s));
			chk(32'(tx_speed_ok), 32'(s != 3));
			chk(32'(tx_sync), 32'(v[3:0]));
		end
		// buffer flags across the thresholds
		foreach (v[k]) begin
			if (k < 8) begin
				m_ctl = (k < 6) ? k : rnd() & 32'hFF;
				m_en = rnd() & 32'h3;
				dp.level(m_ctl[7:0], m_en[7:0]);
				rchk(isoav_pkg::OFS_TX_LVL, {28'h0, m_ctl == 0, m_ctl == 1, m_ctl >= 5, m_en == 0});
			end
		end
		// read-only and unmapped places
		wr(isoav_pkg::OFS_TX_LVL, 32'h00000000);
		rchk(isoav_pkg::OFS_TX_LVL, {28'h0, m_ctl == 0, m_ctl == 1, m_ctl >= 5, m_en == 0});
		wr(9'h03C, 32'hFFFFFFFF);
		rchk(9'h03C, 32'h0);
		// receiver control fields
		for (int i = 0; i < 4; i++) begin
			m_rxc = rnd() & 32'h5F;
			wr(isoav_pkg::OFS_RX_CTL, m_rxc | 32'hFFFFFF20);
			rchk(isoav_pkg::OFS_RX_CTL, m_rxc);
			chk(32'(drop_unreliable_packets), 32'(m_rxc[6]));
			chk(32'(rx_byte_pad_count), 32'(m_rxc[3:2]));
			chk(32'(stamp_processing_enable), 32'(m_rxc[1]));
			chk(32'(rx_soft_reset), 32'(m_rxc[0]));
		end
		// enable follows only at packet arrival
		wr(isoav_pkg::OFS_RX_CTL, 32'h00000010);
		repeat (5) @(posedge sys_clk);
		chk(32'(rx_enable), 32'h0);
		dp.arrive();
		wait_en(1'b1);
		chk(32'(rx_enable), 32'h1);
		wr(isoav_pkg::OFS_RX_CTL, 32'h00000000);
		repeat (5) @(posedge sys_clk);
		chk(32'(rx_enable), 32'h1);
		dp.arrive();
		wait_en(1'b0);
		chk(32'(rx_enable), 32'h0);
		// soft reset drops the running receiver
		wr(isoav_pkg::OFS_RX_CTL, 32'h00000010);
		dp.arrive();
		wait_en(1'b1);
		wr(isoav_pkg::OFS_RX_CTL, 32'h00000011);
		@(posedge sys_clk) #1;
		chk(32'(rx_enable), 32'h0);
		// packet-ready status bit
		dp.ready(1'b1);
		repeat (3) @(posedge sys_clk);
		rchk(isoav_pkg::OFS_RX_CTL, 32'h00000031);
		dp.ready(1'b0);
		repeat (3) @(posedge sys_clk);
		rchk(isoav_pkg::OFS_RX_CTL, 32'h00000011);
		end_of_test();
	end
endmodule : iso_av_tx_rx_control_regs_tb_top
`default_nettype wire
